// file: src/adc_host.sv
// host end: drives start, select and read in each mode, captures results
`timescale 1ns/1ns
`include "adc_port_consts.svh"
module adc_host
  import adc_port_pkg::*;
#(
  parameter int WIDTH = `RESULT_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int ACQ_CYCLES = `ACQ_CYCLES
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  adc_port_if.host port,
  input wire host_mode_t mode_i,
  input wire logic request_i,
  output logic idle_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STROBE,
    ST_WAIT_LOW,
    ST_WAIT_HIGH,
    ST_CAPTURE,
    ST_ACQ
  } host_state_t;

  localparam int AW = $clog2(ACQ_CYCLES + 1);
  host_state_t state_q;
  logic [AW-1:0] acq_q;
  logic strobe_n_q;
  logic read_n_q;
  logic busy_n_q;
  logic cap_valid_q;
  logic [WIDTH-1:0] cap_data_q;
  logic fifo_ready;
  logic tied;

  // slow memory and rom tie read to start
  assign tied = (mode_i == MODE_SLOW_MEMORY) || (mode_i == MODE_ROM);
  assign port.chip_select_n = 1'b0;
  assign port.conversion_start_n = strobe_n_q;
  // always-on keeps read low so the outputs stay enabled
  assign port.read_n = (mode_i == MODE_ALWAYS_ON) ? 1'b0
                       : (tied ? strobe_n_q : read_n_q);
  assign idle_o = (state_q == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      busy_n_q <= 1'b1;
    end else begin
      busy_n_q <= port.busy_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence; new request only taken when the fifo can accept a word
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      strobe_n_q <= 1'b1;
      read_n_q <= 1'b1;
      acq_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (request_i && fifo_ready && !cap_valid_q) begin
            strobe_n_q <= 1'b0;
            read_n_q <= 1'b1;
            state_q <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          // rom: previous result readable on this access, no wait
          if (mode_i != MODE_SLOW_MEMORY) begin
            strobe_n_q <= 1'b1;
          end
          state_q <= ST_WAIT_LOW;
        end
        ST_WAIT_LOW: begin
          if (!busy_n_q) begin
            state_q <= ST_WAIT_HIGH;
          end
        end
        ST_WAIT_HIGH: begin
          if (busy_n_q) begin
            // rom: new result is fetched by the next strobe, a read here would restart
            if (mode_i == MODE_ROM) begin
              acq_q <= AW'(ACQ_CYCLES);
              state_q <= ST_ACQ;
            end else begin
              read_n_q <= 1'b0;
              state_q <= ST_CAPTURE;
            end
          end
        end
        ST_CAPTURE: begin
          // tied strobe rises on the capture edge, so read is still low there
          strobe_n_q <= 1'b1;
          read_n_q <= 1'b1;
          acq_q <= AW'(ACQ_CYCLES);
          state_q <= ST_ACQ;
        end
        ST_ACQ: begin
          if (acq_q == '0) begin
            state_q <= ST_IDLE;
          end else begin
            acq_q <= acq_q - 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture new result once busy is back high, rom result at the strobe; held until fifo takes it
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cap_valid_q <= 1'b0;
      cap_data_q <= '0;
    end else if (state_q == ST_CAPTURE
                 || (state_q == ST_STROBE && mode_i == MODE_ROM)) begin
      cap_valid_q <= 1'b1;
      cap_data_q <= port.data_out;
    end else if (fifo_ready) begin
      cap_valid_q <= 1'b0;
    end
  end

  result_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(cap_valid_q),
    .in_ready_o(fifo_ready),
    .in_data_i(cap_data_q),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(out_data_o)
  );
endmodule : adc_host

// file: src/adc_port_consts.svh
// constants for the converter read port and its host end
// Function
// - start conversion on start low with select low
// - ignore start requests while converting
// - busy low exactly while converting
// - select and read low: data always driven
// - host captures result at busy rising edge (here three edges after it; rom at the strobe)
// - narrow low start pulse starts on fall
// - narrow high start pulse: each fall starts
// - read high: data outputs released
// - host ties read to start, select low
// - busy low stalls host read cycle
// - old result shown during conversion
// - new result latched before busy rises (here on the same edge busy rises)
// - host raises strobe after busy, captures
// - rom mode: strobe starts, returns previous
// - host waits conversion end before next strobe
// - result is two's complement across range
// - internal timing within max conversion time
// - host allows acquisition time before restart
`ifndef ADC_PORT_CONSTS_SVH
`define ADC_PORT_CONSTS_SVH
`define CLK_PERIOD_NS 50
`define CONV_TIME_NS 1150
`define CONV_CYCLES ((`CONV_TIME_NS) / (`CLK_PERIOD_NS))
`define ACQ_TIME_NS 300
`define ACQ_CYCLES (((`ACQ_TIME_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define RESULT_WIDTH 14
`define FIFO_DEPTH 4
`endif

// file: src/adc_port_pkg.sv
// types shared by both ends of the converter read port
package adc_port_pkg;
  typedef enum logic [1:0] {
    MODE_ALWAYS_ON,
    MODE_READ_GATED,
    MODE_SLOW_MEMORY,
    MODE_ROM
  } host_mode_t;
endpackage : adc_port_pkg

// file: src/adc_port_if.sv
// parallel converter port joining the converter and its host
`timescale 1ns/1ns
`include "adc_port_consts.svh"
interface adc_port_if #(
  parameter int WIDTH = `RESULT_WIDTH
);
  logic conversion_start_n;
  logic chip_select_n;
  logic read_n;
  logic busy_n;
  logic [WIDTH-1:0] data_out;
  logic data_oe;

  modport converter (
    input conversion_start_n,
    input chip_select_n,
    input read_n,
    output busy_n,
    output data_out,
    output data_oe
  );
  modport host (
    output conversion_start_n,
    output chip_select_n,
    output read_n,
    input busy_n,
    input data_out,
    input data_oe
  );
endinterface : adc_port_if

// file: src/result_fifo.sv
// small valid/ready fifo holding captured results
`timescale 1ns/1ns
module result_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready_o = (count_q != (AW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : result_fifo

// file: src/adc_converter.sv
// converter end: start detection, internal timing, result latch, data drive
`timescale 1ns/1ns
`include "adc_port_consts.svh"
module adc_converter
  import adc_port_pkg::*;
#(
  parameter int WIDTH = `RESULT_WIDTH,
  parameter int CONV_CYCLES = `CONV_CYCLES
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  adc_port_if.converter port,
  input wire logic [WIDTH-1:0] sample_i,
  output logic converting_o
);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  logic start_n_q;
  logic [CW-1:0] count_q;
  logic busy_q;
  logic [WIDTH-1:0] result_q;
  logic [WIDTH-1:0] held_q;
  logic start_fall;

  ////////////////////////////////////////////////////////////////////////
  // edge detect; start pin sampled each cycle, reset value high = idle
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      start_n_q <= 1'b1;
    end else begin
      start_n_q <= port.conversion_start_n;
    end
  end

  // falling edge only, so a held-low start never retriggers
  assign start_fall = start_n_q && !port.conversion_start_n
                      && !port.chip_select_n;

  ////////////////////////////////////////////////////////////////////////
  // conversion timer, length fixed by the internal clock
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      busy_q <= 1'b0;
      count_q <= '0;
      held_q <= '0;
    end else if (!busy_q) begin
      if (start_fall) begin
        busy_q <= 1'b1;
        count_q <= CW'(CONV_CYCLES - 1);
        held_q <= sample_i;
      end
    end else if (count_q == '0) begin
      busy_q <= 1'b0;
    end else begin
      count_q <= count_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result latch: changes only at the end, same edge busy returns high
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      result_q <= '0;
    end else if (busy_q && count_q == '0) begin
      result_q <= held_q;
    end
  end

  assign port.busy_n = !busy_q;
  assign port.data_out = result_q;
  // drive only with select and read low
  assign port.data_oe = !port.chip_select_n && !port.read_n;
  assign converting_o = busy_q;
endmodule : adc_converter

// file: dv/adc_port_monitor.sv
// assertions on the wires between converter and host
`timescale 1ns/1ns
module adc_port_monitor #(
  parameter int CONV_CYCLES = 23,
  parameter int ACQ_CYCLES = 6
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic conversion_start_n,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic busy_n,
  input wire logic [13:0] data_out,
  input wire logic data_oe
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // counters instead of long repetitions, which tools unroll badly
  int low_q;
  int gap_q;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || busy_n) begin
      low_q <= 0;
    end else begin
      low_q <= low_q + 1;
    end
  end
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      gap_q <= 1000;
    end else if (!busy_n) begin
      gap_q <= 0;
    end else if (gap_q < 1000) begin
      gap_q <= gap_q + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    $fell(conversion_start_n) && !chip_select_n && busy_n;
  endsequence
  property p_start;
    s_start |=> !busy_n;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_len;
    $rose(busy_n) |-> low_q == CONV_CYCLES;
  endproperty
  a_len: assert property (p_len) else $error("busy low length wrong");
  property p_no_restart;
    $rose(busy_n) && !$fell(conversion_start_n) |=> busy_n;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion restarted");
  property p_oe;
    data_oe == (!chip_select_n && !read_n);
  endproperty
  a_oe: assert property (p_oe) else $error("data drive enable wrong");
  property p_hold;
    !$rose(busy_n) |-> $stable(data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("result latch changed");
  property p_cs;
    chip_select_n == 1'b0;
  endproperty
  a_cs: assert property (p_cs) else $error("select not held low");
  property p_acq;
    $fell(conversion_start_n) |-> gap_q >= ACQ_CYCLES;
  endproperty
  a_acq: assert property (p_acq) else $error("acquisition gap short");
  property p_wait;
    !busy_n |-> !$fell(conversion_start_n);
  endproperty
  a_wait: assert property (p_wait) else $error("strobe during conversion");
endmodule : adc_port_monitor

// file: dv/adc_conversion_read_port_bench.sv
// bench joining converter and host, with a queue model of results
`timescale 1ns/1ns
module adc_conversion_read_port_bench;
  import adc_port_pkg::*;
  localparam int CONV = 3;
  localparam int ACQ = 1;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  host_mode_t mode_i = MODE_ALWAYS_ON;
  logic request_i = 1'b0;
  logic out_ready_i = 1'b0;
  logic [13:0] sample_i = 14'h1a5c;
  logic idle_o, out_valid_o, converting_o;
  logic busy_q = 1'b1;
  logic [13:0] out_data_o;
  logic [13:0] last_v = 14'h0000;
  logic [13:0] exp_q[$];
  integer seed = 32'h5c584abe;
  int error_cnt = 0;
  int n_tests = 0;
  int k;
  adc_port_if port ();
  adc_converter #(.CONV_CYCLES(CONV)) adc_converter_inst (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .port(port), .sample_i(sample_i), .converting_o(converting_o));
  adc_host #(.ACQ_CYCLES(ACQ)) adc_host_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .port(port), .mode_i(mode_i), .request_i(request_i), .idle_o(idle_o),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o));
  adc_port_monitor #(.CONV_CYCLES(CONV), .ACQ_CYCLES(ACQ)) adc_port_monitor_inst (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .conversion_start_n(port.conversion_start_n),
    .chip_select_n(port.chip_select_n), .read_n(port.read_n), .busy_n(port.busy_n),
    .data_out(port.data_out), .data_oe(port.data_oe));
  always #25 clock_i = ~clock_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////
  // sample only moves while busy, so the value held at each start is known
  always @(posedge clock_i) begin
    busy_q <= sys_rst_i ? 1'b1 : port.busy_n;
    // rom access returns the result standing before the new start
    if (!sys_rst_i && busy_q && !port.busy_n) begin
      exp_q.push_back((mode_i == MODE_ROM) ? last_v : sample_i);
      last_v = sample_i;
      sample_i <= 14'($random(seed));
      check("converting", 14'h0001, {13'h0000, converting_o});
    end
    if (!sys_rst_i && !busy_q && port.busy_n) begin
      check("latch", last_v, port.data_out);
      check("idle", 14'h0000, {13'h0000, converting_o});
    end
    if (!sys_rst_i && out_valid_o && out_ready_i) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("CHECK FAILED fifo expected none seen %h", out_data_o);
      end else begin
        check("fifo word", exp_q.pop_front(), out_data_o);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // first mode: fifo filled with consumer stalled, later modes start with consumer ready; then random drain
  initial begin
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      @(posedge clock_i);
      mode_i <= host_mode_t'(m);
      request_i <= 1'b1;
      repeat (60) @(posedge clock_i);
      for (int i = 0; i < 200; i++) begin
        @(posedge clock_i);
        out_ready_i <= ($random(seed) & 3) != 0;
      end
      @(posedge clock_i);
      request_i <= 1'b0;
      out_ready_i <= 1'b1;
      for (k = 0; k < 400 && !(idle_o === 1'b1 && exp_q.size() == 0); k++) begin
        @(posedge clock_i);
      end
      if (k == 400) begin
        error_cnt++;
        complete_run();
      end
      $display("mode %0d done, %0d checks", m, n_tests);
    end
    complete_run();
  end
endmodule : adc_conversion_read_port_bench
